// *** sor_pkg.sv ***
// constants for the indexed system option register block
package sor_pkg;

  localparam int          IO_ADDR_W      = 16;
  localparam logic [15:0] INDEX_PORT     = 16'h0022;
  localparam logic [15:0] DATA_PORT      = 16'h0023;
  localparam logic [7:0]  OPTION_INDEX   = 8'h8f;
  localparam logic [7:0]  INDEX_RESET    = 8'h00;

  // system_option_select layout
  localparam int          BIT_MM_FAST    = 0;
  localparam int          BIT_FAST_VIDEO = 1;
  localparam int          BIT_RD_EXTEND  = 2;
  localparam logic [7:0]  OPTION_RESET   = 8'h04;
  localparam logic [7:0]  OPTION_MASK    = 8'h07;

  // processor speed codes from the speed select register
  localparam logic [1:0]  SPEED_16       = 2'h0;
  localparam logic [1:0]  SPEED_20       = 2'h1;

  // matched-memory cycle times, picoseconds, and least cycle counts
  localparam int CLK_PERIOD_PS  = 40000;
  localparam int MM_SLOW_16_PS  = 250000;
  localparam int MM_SLOW_20_PS  = 250000;
  localparam int MM_SLOW_25_PS  = 240000;
  localparam int MM_FAST_16_PS  = 187500;
  localparam int MM_FAST_20_PS  = 150000;
  localparam int MM_FAST_25_PS  = 120000;
  localparam int MM_SLOW_16_CYC =
    (MM_SLOW_16_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int MM_SLOW_20_CYC =
    (MM_SLOW_20_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int MM_SLOW_25_CYC =
    (MM_SLOW_25_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int MM_FAST_16_CYC =
    (MM_FAST_16_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int MM_FAST_20_CYC =
    (MM_FAST_20_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int MM_FAST_25_CYC =
    (MM_FAST_25_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // reset input recognition and reset output pulse, in clock cycles
  localparam int RESET_MIN_CYC   = 3;
  localparam int RESET_PULSE_CYC = 128;

  typedef enum logic [1:0] {
    SOR_IDLE,
    SOR_MM,
    SOR_WAIT_RDY,
    SOR_EXTRA
  } sor_state_e;

endpackage : sor_pkg

// *** sor_sync.sv ***
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module sor_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] async_in,
  input  wire logic [WIDTH-1:0] reset_value_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;

  // reset_value_in is a constant tie at every instance
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta     <= reset_value_in;
      sync_out <= reset_value_in;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule : sor_sync

// *** sor_top.sv ***
// indexed system option register with cycle sequencer and reset pulses
//
// Overview of operation
// R1: index 8fh written at port 22h selects register; port 23h moves data.
// R2: bit 0 clear: matched-memory cycle 250 ns at 16/20 MHz, 240 at 25.
// R3: bit 0 set: matched-memory cycle 187.5, 150, 120 ns by speed.
// R4: bit 0 is matched-memory fast cycle select, resets to 0.
// R5: bit 1 set makes video-adapter accesses fast video cycles.
// R6: bit 1 reads 0 after reset.
// R7: a fast video cycle stretches until channel ready returns active.
// R8: bit 2 set adds exactly one wait state after channel ready seen.
// R9: that extra wait state applies to reads only, never writes.
// R10: bit 2 reads 1 after reset.
// R11: processor and aux reset outputs pulse at most 128 clocks.
// R12: outside reset input must be held low at least three clocks.
// R13: fast video cycle drives only the video strobe, not bus strobe.
// R14: reserved bits 3 to 7 read zero, writes to them ignored.
`timescale 1ns/1ps
module sor_top (
  input  wire logic                          clk_in,
  input  wire logic                          rst_in,
  input  wire logic [sor_pkg::IO_ADDR_W-1:0] io_addr_in,
  input  wire logic                          io_wr_in,
  input  wire logic                          io_rd_in,
  input  wire logic [7:0]                    io_wdata_in,
  output logic      [7:0]                    io_rdata_out,
  input  wire logic [1:0]                    speed_sel_in,
  input  wire logic                          mm_req_in,
  input  wire logic                          bus_req_in,
  input  wire logic                          bus_write_in,
  input  wire logic                          video_sel_in,
  input  wire logic                          channel_ready_in,
  input  wire logic                          system_reset_in_n,
  output logic                               mm_command_n_out,
  output logic                               bus_command_strobe_n_out,
  output logic                               fast_video_command_n_out,
  output logic                               cycle_done_out,
  output logic                               processor_reset_out,
  output logic                               aux_reset_out
);
  import sor_pkg::*;

  logic [7:0] index_reg;
  logic [7:0] system_option_select;
  logic [5:0] pins_sync;
  logic       mm_req_d;
  logic       bus_req_d;
  logic       cyc_write;
  logic       cyc_fast;
  logic [3:0] mm_cnt;
  logic [1:0] low_cnt;
  logic       pulse_on;
  logic [7:0] pulse_cnt;
  sor_state_e state;
  sor_state_e next_state;

  // pins come from the far side of the chip; sample before use
  sor_sync #(
    .WIDTH          (6)
  ) i_sor_sync (
    .clk_in         (clk_in),
    .rst_in         (rst_in),
    .async_in       ({system_reset_in_n, channel_ready_in, video_sel_in,
                      bus_write_in, bus_req_in, mm_req_in}),
    .reset_value_in (6'h20),
    .sync_out       (pins_sync)
  );

  wire mm_req_s  = pins_sync[0];
  wire bus_req_s = pins_sync[1];
  wire write_s   = pins_sync[2];
  wire video_s   = pins_sync[3];
  wire channel_ready_in_s   = pins_sync[4];
  wire sysrst_ns = pins_sync[5];

  // third consecutive low sample recognises the outside reset
  wire sys_reset_seen = !sysrst_ns &&
                        (low_cnt == 2'(RESET_MIN_CYC - 1)); // see R12
  wire soft_reset     = rst_in || sys_reset_seen;

  // register port decode
  wire index_wr  = io_wr_in && (io_addr_in == INDEX_PORT);
  wire data_hit  = (io_addr_in == DATA_PORT) &&
                   (index_reg == OPTION_INDEX);           // see R1
  wire option_wr = io_wr_in && data_hit;
  wire [7:0] rd_mux =
    (io_addr_in == INDEX_PORT) ? index_reg :
    data_hit                   ? system_option_select : 8'h00;

  wire opt_mm_fast   = system_option_select[BIT_MM_FAST];
  wire opt_fast_vid  = system_option_select[BIT_FAST_VIDEO];
  wire opt_rd_extend = system_option_select[BIT_RD_EXTEND];

  // counter load, one less than the matched-memory access cycles, by speed and bit 0
  function automatic logic [3:0] mm_cycles(input logic [1:0] speed,
                                           input logic       fast);
    int n;
    if (fast) begin
      n = (speed == SPEED_16) ? MM_FAST_16_CYC :
          (speed == SPEED_20) ? MM_FAST_20_CYC :
                                MM_FAST_25_CYC;           // see R3
    end else begin
      n = (speed == SPEED_16) ? MM_SLOW_16_CYC :
          (speed == SPEED_20) ? MM_SLOW_20_CYC :
                                MM_SLOW_25_CYC;           // see R2
    end
    return 4'(n - 1);
  endfunction : mm_cycles

  wire mm_start  = mm_req_s && !mm_req_d;
  wire bus_start = bus_req_s && !bus_req_d;
  wire rdy_end   = (state == SOR_WAIT_RDY) && channel_ready_in_s;    // see R7
  wire want_extra = rdy_end && !cyc_write && opt_rd_extend; // see R8 R9
  wire mm_end    = (state == SOR_MM) && (mm_cnt == 4'h0);
  wire cyc_end   = mm_end || (rdy_end && !want_extra) ||
                   (state == SOR_EXTRA);

  always_comb begin
    next_state = state;
    unique case (state)
      SOR_IDLE: begin
        if (mm_start) begin
          next_state = SOR_MM;
        end else if (bus_start) begin
          next_state = SOR_WAIT_RDY;
        end
      end
      SOR_MM: begin
        if (mm_end) begin
          next_state = SOR_IDLE;
        end
      end
      SOR_WAIT_RDY: begin
        if (want_extra) begin
          next_state = SOR_EXTRA;                         // see R8
        end else if (rdy_end) begin
          next_state = SOR_IDLE;
        end
      end
      SOR_EXTRA: begin
        next_state = SOR_IDLE;
      end
    endcase
  end

  // strobes for the state being entered, so they are flop outputs
  wire next_bus_cyc = (next_state == SOR_WAIT_RDY) ||
                      (next_state == SOR_EXTRA);
  wire next_fast    = (state == SOR_IDLE) ?
                      (video_s && opt_fast_vid) : cyc_fast; // see R5

  // register file; a recognised outside reset restores defaults
  always_ff @(posedge clk_in) begin
    if (soft_reset) begin
      index_reg            <= INDEX_RESET;
      system_option_select <= OPTION_RESET;            // see R4 R6 R10
    end else begin
      if (index_wr) begin
        index_reg <= io_wdata_in;
      end
      if (option_wr) begin
        system_option_select <= io_wdata_in & OPTION_MASK; // see R14
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      io_rdata_out <= 8'h00;
    end else if (io_rd_in) begin
      io_rdata_out <= rd_mux;                             // see R1
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state                    <= SOR_IDLE;
      mm_req_d                 <= 1'b0;
      bus_req_d                <= 1'b0;
      cyc_write                <= 1'b0;
      cyc_fast                 <= 1'b0;
      mm_cnt                   <= 4'h0;
      cycle_done_out           <= 1'b0;
      mm_command_n_out         <= 1'b1;
      bus_command_strobe_n_out <= 1'b1;
      fast_video_command_n_out <= 1'b1;
    end else begin
      state     <= next_state;
      mm_req_d  <= mm_req_s;
      bus_req_d <= bus_req_s;
      if (state == SOR_IDLE) begin
        cyc_write <= write_s;
        cyc_fast  <= next_fast;
        mm_cnt    <= mm_cycles(speed_sel_in, opt_mm_fast);
      end else if (mm_cnt != 4'h0) begin
        mm_cnt <= mm_cnt - 4'h1;
      end
      cycle_done_out           <= cyc_end;
      mm_command_n_out         <= !(next_state == SOR_MM);
      // ordinary cycles copy the strobe onto the video command too
      bus_command_strobe_n_out <= !(next_bus_cyc && !next_fast); // see R13
      fast_video_command_n_out <= !next_bus_cyc;
    end
  end

  // outside reset: count low samples, then a fixed-length output pulse
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      low_cnt   <= 2'h0;
      pulse_on  <= 1'b0;
      pulse_cnt <= 8'h00;
    end else begin
      if (sysrst_ns) begin
        low_cnt <= 2'h0;
      end else if (low_cnt != 2'h3) begin
        low_cnt <= low_cnt + 2'h1;
      end
      // the pulse ends on count even if the input stays low
      if (sys_reset_seen) begin
        pulse_on  <= 1'b1;
        pulse_cnt <= 8'h00;
      end else if (pulse_on) begin
        pulse_cnt <= pulse_cnt + 8'h01;
        if (pulse_cnt == 8'(RESET_PULSE_CYC - 1)) begin
          pulse_on <= 1'b0;                               // see R11
        end
      end
    end
  end

  assign processor_reset_out = pulse_on;
  assign aux_reset_out       = pulse_on;

endmodule : sor_top

// *** sor_top_assertions.sv ***
// port-level checks for the option register block
`timescale 1ns/1ps
module sor_top_assertions (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic mm_command_n_out,
  input wire logic bus_command_strobe_n_out,
  input wire logic fast_video_command_n_out,
  input wire logic cycle_done_out,
  input wire logic processor_reset_out,
  input wire logic aux_reset_out
);
  logic [7:0] rst_len;
  // saturates so a stuck reset output cannot wrap back to a legal count
  always_ff @(posedge clk_in) begin
    if (rst_in || !processor_reset_out) rst_len <= 8'h00;
    else if (rst_len != 8'hff) rst_len <= rst_len + 8'h01;
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  bus_needs_video_a: assert property (
    !bus_command_strobe_n_out |-> !fast_video_command_n_out)
    else $error("bus strobe without video strobe");
  mm_alone_a: assert property (
    !mm_command_n_out |-> bus_command_strobe_n_out && fast_video_command_n_out)
    else $error("strobes overlap a memory cycle");
  mm_min_len_a: assert property (
    $fell(mm_command_n_out) |-> !mm_command_n_out [*3])
    else $error("memory cycle too short");
  mm_max_len_a: assert property (
    $fell(mm_command_n_out) |-> ##[1:7] $rose(mm_command_n_out))
    else $error("memory cycle too long");
  mm_done_a: assert property (
    $rose(mm_command_n_out) |-> cycle_done_out)
    else $error("memory cycle end without done");
  video_done_a: assert property (
    $rose(fast_video_command_n_out) |-> cycle_done_out)
    else $error("video cycle end without done");
  done_pulse_a: assert property (
    cycle_done_out |=> !cycle_done_out)
    else $error("done longer than one cycle");
  reset_len_a: assert property (
    processor_reset_out |-> rst_len < 8'h80)
    else $error("reset pulse too long");
  reset_pair_a: assert property (
    aux_reset_out == processor_reset_out)
    else $error("reset outputs differ");
  cover property ($fell(mm_command_n_out));
  cover property (!fast_video_command_n_out && bus_command_strobe_n_out);
  cover property ($fell(processor_reset_out));
endmodule : sor_top_assertions
bind sor_top sor_top_assertions i_sor_top_assertions (
  .clk_in, .rst_in, .mm_command_n_out, .bus_command_strobe_n_out,
  .fast_video_command_n_out, .cycle_done_out, .processor_reset_out,
  .aux_reset_out);

// *** sor_adapter_model.sv ***
// channel adapter that holds channel ready low to stretch a cycle
`timescale 1ns/1ps
module sor_adapter_model (
  input  wire logic       clk_in,
  input  wire logic       bus_req_in,
  input  wire logic [3:0] stall_in,
  output logic            channel_ready_out
);
  logic       req_q = 1'b0;
  logic [3:0] left = 4'h0;
  always_ff @(posedge clk_in) begin
    req_q <= bus_req_in;
    if (bus_req_in && !req_q) left <= stall_in;
    else if (left != 4'h0) left <= left - 4'h1;
  end
  // low for stall_in cycles from the clock after the request edge; never low when stall_in is 0
  assign channel_ready_out = (left == 4'h0);
endmodule : sor_adapter_model

// *** sor_top_tb.sv ***
// self-checking bench for the option register block
`timescale 1ns/1ps
module sor_top_tb;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [15:0] io_addr_in = 16'h0000;
  logic        io_wr_in = 1'b0;
  logic        io_rd_in = 1'b0;
  logic [7:0]  io_wdata_in = 8'h00;
  logic [7:0]  io_rdata_out;
  logic [1:0]  speed_sel_in = 2'h0;
  logic        mm_req_in = 1'b0;
  logic        bus_req_in = 1'b0;
  logic        bus_write_in = 1'b0;
  logic        video_sel_in = 1'b0;
  logic        channel_ready_in;
  logic        system_reset_in_n = 1'b1;
  logic        mm_command_n_out;
  logic        bus_command_strobe_n_out;
  logic        fast_video_command_n_out;
  logic        cycle_done_out;
  logic        processor_reset_out;
  logic        aux_reset_out;
  logic [3:0]  stall = 4'h0;
  int          fail_count = 0;
  int          samples_checked = 0;
  int          seed = 82100;
  int          opt_m;
  int          la, lb, lc;
  logic        ba, bb;
  // shadow of the index and option registers, kept from the rules
  logic [7:0]  idx_m = 8'h00;
  logic [7:0]  opt_mdl = 8'h04;
  int          mm_ps [8] = '{250000, 250000, 240000, 240000,
                             187500, 150000, 120000, 120000};
  sor_top i_sor_top (.*);
  sor_adapter_model i_sor_adapter_model (.clk_in, .bus_req_in,
    .stall_in(stall), .channel_ready_out(channel_ready_in));
  initial forever #20 clk_in = ~clk_in;
  function automatic int xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_in);
    io_addr_in <= a;
    io_wdata_in <= d;
    io_wr_in <= 1'b1;
    @(posedge clk_in);
    io_wr_in <= 1'b0;
    if (a == 16'h0022) idx_m = d;
    if (a == 16'h0023 && idx_m == 8'h8f) opt_mdl = d & 8'h07;
  endtask : io_wr
  task automatic io_rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    io_addr_in <= a;
    io_rd_in <= 1'b1;
    @(posedge clk_in);
    io_rd_in <= 1'b0;
    #1 check(io_rdata_out, exp);
  endtask : io_rd
  // counts strobe-low cycles up to the done pulse, with a bounded wait
  task automatic cyc(input logic m, input logic w, input logic v,
                     output int len, output logic bs);
    len = 0;
    bs = 1'b0;
    @(posedge clk_in);
    mm_req_in <= m;
    bus_req_in <= !m;
    bus_write_in <= w;
    video_sel_in <= v;
    for (int i = 0; i < 60 && cycle_done_out !== 1'b1; i++) begin
      @(posedge clk_in);
      #1 len += m ? !mm_command_n_out : !fast_video_command_n_out;
      bs |= !bus_command_strobe_n_out;
    end
    check(8'(cycle_done_out), 8'h01);
    @(posedge clk_in);
    mm_req_in <= 1'b0;
    bus_req_in <= 1'b0;
    repeat (4) @(posedge clk_in);
  endtask : cyc
  initial begin
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    io_rd(16'h0023, 8'h00);
    io_wr(16'h0022, 8'h8f);
    io_rd(16'h0023, 8'h04);
    io_rd(16'h0024, 8'h00);
    repeat (6) begin
      opt_m = xs();
      io_wr(16'h0023, 8'(opt_m));
      io_rd(16'h0023, opt_mdl);
    end
    // data port with another index must neither store nor return data
    io_wr(16'h0022, 8'h8e);
    io_wr(16'h0023, 8'hff);
    io_rd(16'h0023, 8'h00);
    io_wr(16'h0022, 8'h8f);
    io_rd(16'h0023, opt_mdl);
    io_rd(16'h0022, 8'h8f);
    for (int k = 0; k < 8; k++) begin
      @(posedge clk_in);
      speed_sel_in <= 2'(k);
      io_wr(16'h0023, 8'(4 + k / 4));
      cyc(1'b1, 1'b0, 1'b0, la, ba);
      check(8'(la), 8'((mm_ps[k] + 39999) / 40000));
    end
    io_wr(16'h0023, 8'h06);
    cyc(1'b0, 1'b0, 1'b1, la, ba);
    check(8'(ba), 8'h00);
    cyc(1'b0, 1'b0, 1'b0, lb, bb);
    check(8'(bb), 8'h01);
    cyc(1'b0, 1'b1, 1'b0, lc, bb);
    check(8'(lb - lc), 8'h01);
    io_wr(16'h0023, 8'h00);
    cyc(1'b0, 1'b0, 1'b1, la, ba);
    check(8'(ba), 8'h01);
    check(8'(la - lc), 8'h00);
    stall <= 4'(xs()) | 4'h4;
    cyc(1'b0, 1'b1, 1'b0, lb, bb);
    check(8'(lb > lc), 8'h01);
    system_reset_in_n <= 1'b0;
    lb = 0;
    lc = 0;
    repeat (150) begin
      @(posedge clk_in);
      #1 lb += processor_reset_out;
      lc += aux_reset_out;
    end
    @(posedge clk_in);
    system_reset_in_n <= 1'b1;
    check(8'(lb), 8'h80);
    check(8'(lc), 8'h80);
    io_wr(16'h0022, 8'h8f);
    io_rd(16'h0023, 8'h04);
    finish_test();
  end
  initial begin
    repeat (5000) @(posedge clk_in);
    fail_count++;
    finish_test();
  end
endmodule : sor_top_tb
